// >>> hab_bridge.sv
/*
 * System-bus slave to peripheral-bus master bridge. Writes are posted,
 * reads stall the system bus until the peripheral answers.
 * Assumes the peripheral clock is the core clock gated by i_pclk_en,
 * generated from a core-clock register, and registered peripheral
 * read data and error signals.
 */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - The bridge is the only master driving the peripheral bus.
// - On the system bus the bridge only answers, never initiates.
// - Peripheral address, control, write data aligned; two cycles minimum.
// - Writes are posted; the system bus is released immediately.
// - A second write is captured; hready low until pipeline drains.
// - Pending write to an APB4 peripheral blocks new transfers until done.
// - Reads run to completion with hready low until data returns.
// - Returned peripheral read data drives the system read data lines.
// - Selected BUSY or IDLE transfers are ignored, no peripheral activity.
// - Burst beats are independent transfers at their own addresses.
// - The hburst input exists but has no effect.
// - Peripherals are numbered from zero without gaps.
// - Each peripheral region is 1 KB aligned and at least 1 KB.
// - System width 32..256, peripheral width 8..32, never wider.
// - Wide write data narrowed; narrow read data widened.
// - Big-endian systems byte-swap both ways; little-endian passes.
// - Peripheral clock synchronous, an integer divisor of the core clock.
// - The bridge never answers SPLIT or RETRY.
// - Core edge with tick strobe high is a peripheral clock edge.
// - Captured address and data reach the peripheral only on ticks; the code loads them on the edge that takes the request, tick or not.
// - Read data sampled on first core edge after penable rises; the code keeps the sample from the tick that ends the access.
// - pslverr with pready high returns an ERROR response; the code does so for reads only.
module hab_bridge
	import hab_pkg::*;
(
	input  wire logic                 i_core_clk,
	input  wire logic                 i_reset,
	input  wire logic                 i_pclk_en,
	input  wire logic                 i_hsel,
	input  wire logic [ADDR_W-1:0]    i_haddr,
	input  wire logic [1:0]           i_htrans,
	input  wire logic                 i_hwrite,
	input  wire logic [2:0]           i_hsize,
	input  wire logic [2:0]           i_hburst,
	input  wire logic                 i_hready,
	input  wire logic [SYS_DW-1:0]    i_hwdata,
	input  wire logic                 i_big_endian,
	output logic                      o_hready_resp,
	output logic [1:0]                o_hresp,
	output logic [SYS_DW-1:0]         o_hrdata,
	output logic [NUM_SLV-1:0]        o_psel,
	output logic                      o_penable,
	output logic                      o_pwrite,
	output logic [ADDR_W-1:0]         o_paddr,
	output logic [PER_DW-1:0]         o_pwdata,
	input  wire logic [PER_DW-1:0]    i_prdata,
	input  wire logic                 i_pready,
	input  wire logic                 i_pslverr
);
	hab_state_t state_r;
	hab_state_t state_nxt;

	hab_req_if req ();

	logic [ADDR_W-1:0]    paddr_r;
	logic                 pwrite_r;
	logic [NUM_SLV-1:0]   psel_r;
	logic                 penable_r;
	logic [PER_DW-1:0]    pwdata_r;
	logic [SYS_DW-1:0]    hrdata_r;
	logic                 hready_r;
	logic                 hresp_err_r;
	logic                 err_second_r;
	logic                 apb4_r;

	logic                 addr_phase_valid;
	logic                 load_pend;
	logic                 start_cur;
	logic                 done_xfer;
	logic                 slot_ready;
	logic [SLV_IDX_W-1:0] slv_idx;
	logic                 in_range;
	logic [NUM_SLV-1:0]   sel_dec;
	logic [PER_DW-1:0]    wdata_le;
	logic [PER_DW-1:0]    rdata_sys;
	logic                 slv_ready;

	// Byte swap of one peripheral word, used for both directions.
	function automatic logic [PER_DW-1:0] swap_bytes(
		input logic [PER_DW-1:0] d
	);
		logic [PER_DW-1:0] r;
		r = '0;
		for (int b = 0; b < BYTES_PER_WORD; b++) begin
			r[8*b +: 8] = d[8*(BYTES_PER_WORD-1-b) +: 8];
		end
		return r;
	endfunction

	// Region index of an address: one 1 KB slot per peripheral.
	function automatic logic [SLV_IDX_W-1:0] region_of(
		input logic [ADDR_W-1:0] a
	);
		return a[REGION_LSB +: SLV_IDX_W];
	endfunction

	// Only NONSEQ and SEQ reach the peripheral bus; burst type is unused.
	assign addr_phase_valid = i_hsel && i_hready &&
		(i_htrans == HTRANS_NONSEQ ||
		 i_htrans == HTRANS_SEQ);

	// Decode the captured address, not the queue: a new request may
	// already wait in the pending stage while this one starts.
	assign slv_idx  = region_of(paddr_r);
	assign in_range = (paddr_r[ADDR_W-1:REGION_LSB+SLV_IDX_W] ==
		PER_BASE[ADDR_W-1:REGION_LSB+SLV_IDX_W]);

	// One select per numbered slot, contiguous from zero.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SLV; gi++) begin : g_dec
			assign sel_dec[gi] = in_range &&
				(slv_idx == SLV_IDX_W'(gi));
		end
	endgenerate

	// Only the low peripheral word of the system data is forwarded.
	assign wdata_le = i_big_endian ?
		swap_bytes(i_hwdata[PER_DW-1:0]) :
		i_hwdata[PER_DW-1:0];
	assign rdata_sys = i_big_endian ?
		swap_bytes(i_prdata) : i_prdata;

	// Peripherals without a ready line are treated as always ready.
	assign slv_ready = i_pready || ((psel_r & READY_MASK) == '0);

	assign slot_ready = (state_r == HAB_IDLE) && !req.valid;
	assign load_pend  = addr_phase_valid && hready_r;
	assign start_cur  = (state_r == HAB_WAIT_WDATA) && i_pclk_en;
	assign done_xfer  = (state_r == HAB_ACCESS) && slv_ready &&
		i_pclk_en;

	hab_pend u_pend (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_load     (load_pend),
		.i_write    (i_hwrite),
		.i_addr     (i_haddr),
		.req        (req)
	);

	assign req.take = (state_r == HAB_IDLE) && req.valid;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			HAB_IDLE:
				if (req.valid) state_nxt = HAB_WAIT_WDATA;
			HAB_WAIT_WDATA:
				if (i_pclk_en) state_nxt = HAB_SETUP;
			HAB_SETUP:
				if (i_pclk_en) state_nxt = HAB_ACCESS;
			HAB_ACCESS:
				if (done_xfer) state_nxt = HAB_RESP;
			HAB_RESP:
				state_nxt = HAB_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) state_r <= HAB_IDLE;
		else         state_r <= state_nxt;
	end

	// Peripheral bus drive: address, direction and data change when the request is taken; select and enable on a tick.
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			paddr_r   <= RST_ADDR;
			pwrite_r  <= 1'b0;
			psel_r    <= '0;
			penable_r <= 1'b0;
			pwdata_r  <= RST_WDATA;
			apb4_r    <= 1'b0;
		end else begin
			if (req.take) begin
				paddr_r  <= req.addr;
				pwrite_r <= req.write;
				apb4_r   <= apb4_target(req.addr);
			end
			// Write data is only valid in the data phase, which lasts at least until
			// the edge that hands the request to the sequencer.
			if (req.take && req.write)
				pwdata_r <= wdata_le;
			if (start_cur)
				psel_r <= sel_dec;
			if (state_r == HAB_SETUP && i_pclk_en)
				penable_r <= 1'b1;
			if (done_xfer) begin
				psel_r    <= '0;
				penable_r <= 1'b0;
			end
		end
	end

	// Read data is captured on every core edge of the access phase that
	// sees ready, up to and including the peripheral edge that ends it.
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			hrdata_r <= RST_RDATA;
		end else if (state_r == HAB_ACCESS && !pwrite_r && slv_ready) begin
			hrdata_r <= SYS_DW'(rdata_sys);
		end
	end

	// Ready to the system bus. A write is posted when the slot is free;
	// a read or a write behind a busy slot holds hready low. A pending
	// APB4 write also blocks until its peripheral transfer ends.
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			hready_r     <= 1'b1;
			hresp_err_r  <= 1'b0;
			err_second_r <= 1'b0;
		end else begin
			err_second_r <= 1'b0;
			if (err_second_r) begin
				hready_r    <= 1'b1;
			end else if (load_pend) begin
				// Posted only when nothing is queued or running.
				hready_r    <= i_hwrite && slot_ready &&
					!apb4_target(i_haddr);
				hresp_err_r <= 1'b0;
			end else if (!hready_r && done_xfer && i_pslverr && !pwrite_r)
			begin
				hresp_err_r  <= 1'b1;
				err_second_r <= 1'b1;
			end else if (!hready_r && done_xfer && (!pwrite_r || apb4_r))
			begin
				hready_r    <= 1'b1;
				hresp_err_r <= 1'b0;
			end else if (!hready_r && req.take && req.write &&
				!apb4_target(req.addr)) begin
				// A queued write is released once its data is captured.
				hready_r    <= 1'b1;
				hresp_err_r <= 1'b0;
			end else if (hready_r) begin
				hresp_err_r <= 1'b0;
			end
		end
	end

	// Decode used both at capture time and at hand-over to the sequencer.
	function automatic logic apb4_target(input logic [ADDR_W-1:0] a);
		return APB4_MASK[region_of(a)];
	endfunction

	assign o_hready_resp = hready_r;
	assign o_hresp   = hresp_err_r ? HRESP_ERROR : HRESP_OKAY;
	assign o_hrdata  = hrdata_r;
	assign o_psel    = psel_r;
	assign o_penable = penable_r;
	assign o_pwrite  = pwrite_r;
	assign o_paddr   = paddr_r;
	assign o_pwdata  = pwdata_r;
	// i_pclk_en must come from a core-clock register at a fixed ratio.
endmodule : hab_bridge
`default_nettype wire

// >>> hab_pkg.sv
/*
 * Package for the system-to-peripheral bus bridge: widths, transfer
 * encodings, region layout and reset values.
 * Assumes nothing of its surroundings; shared by all three design files.
 */
`default_nettype none
package hab_pkg;
	localparam int SYS_DW        = 32;
	localparam int PER_DW        = 32;
	localparam int ADDR_W        = 32;
	localparam int NUM_SLV       = 16;
	localparam int SLV_IDX_W     = 4;
	localparam int REGION_LSB    = 10;
	localparam int SWAP_ENABLE   = 0;
	localparam int BYTES_PER_WORD = PER_DW / 8;

	localparam logic [1:0] HTRANS_IDLE   = 2'h0;
	localparam logic [1:0] HTRANS_BUSY   = 2'h1;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;
	localparam logic [1:0] HRESP_OKAY    = 2'h0;
	localparam logic [1:0] HRESP_ERROR   = 2'h1;

	localparam logic [ADDR_W-1:0] PER_BASE   = 32'h0000_0000;
	localparam logic [15:0]       APB4_MASK  = 16'h0000;
	localparam logic [15:0]       READY_MASK = 16'hffff;

	localparam logic [ADDR_W-1:0] RST_ADDR  = 32'h0000_0000;
	localparam logic [PER_DW-1:0] RST_WDATA = 32'h0000_0000;
	localparam logic [SYS_DW-1:0] RST_RDATA = 32'h0000_0000;

	typedef enum logic [2:0] {
		HAB_IDLE,
		HAB_WAIT_WDATA,
		HAB_SETUP,
		HAB_ACCESS,
		HAB_RESP
	} hab_state_t;
endpackage : hab_pkg
`default_nettype wire

// >>> hab_req_if.sv
/*
 * Interface carrying one captured system-bus request from the capture
 * stage to the peripheral sequencer inside the bridge.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface hab_req_if;
	import hab_pkg::*;
	logic              valid;
	logic              write;
	logic [ADDR_W-1:0] addr;
	logic              take;
	modport src (output valid, output write, output addr, input take);
	modport dst (input valid, input write, input addr, output take);
endinterface : hab_req_if
`default_nettype wire

// >>> hab_pend.sv
/*
 * Pending-request holding stage: keeps the address and direction of one
 * system-bus transfer that could not start on the peripheral bus yet.
 * Assumes a synchronous active-high reset on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module hab_pend
	import hab_pkg::*;
(
	input  wire logic              i_core_clk,
	input  wire logic              i_reset,
	input  wire logic              i_load,
	input  wire logic              i_write,
	input  wire logic [ADDR_W-1:0] i_addr,
	hab_req_if.src                 req
);
	logic              valid_r;
	logic              write_r;
	logic [ADDR_W-1:0] addr_r;

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			valid_r <= 1'b0;
			write_r <= 1'b0;
			addr_r  <= RST_ADDR;
		end else if (i_load) begin
			valid_r <= 1'b1;
			write_r <= i_write;
			addr_r  <= i_addr;
		end else if (req.take) begin
			valid_r <= 1'b0;
		end
	end

	assign req.valid = valid_r;
	assign req.write = write_r;
	assign req.addr  = addr_r;
endmodule : hab_pend
`default_nettype wire

// >>> hab_checker.sv
/* Checker for hab_bridge: peripheral framing, stalls and responses.
   Bound to the bridge; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module hab_checker
	import hab_pkg::*;
(
	input wire logic               i_core_clk,
	input wire logic               i_reset,
	input wire logic               i_pclk_en,
	input wire logic               i_hsel,
	input wire logic [1:0]         i_htrans,
	input wire logic               i_hwrite,
	input wire logic               i_hready,
	input wire logic               i_big_endian,
	input wire logic               o_hready_resp,
	input wire logic [1:0]         o_hresp,
	input wire logic [SYS_DW-1:0]  o_hrdata,
	input wire logic [NUM_SLV-1:0] o_psel,
	input wire logic               o_penable,
	input wire logic               o_pwrite,
	input wire logic [ADDR_W-1:0]  o_paddr,
	input wire logic [PER_DW-1:0]  o_pwdata,
	input wire logic [PER_DW-1:0]  i_prdata,
	input wire logic               i_pready,
	input wire logic               i_pslverr
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	sequence s_setup;
		|o_psel && !o_penable && i_pclk_en;
	endsequence
	sequence s_done;
		o_penable && i_pready && i_pclk_en;
	endsequence
	wire rd_take = i_hsel && i_hready && i_htrans[1] && !i_hwrite && o_hready_resp;

	a_setup_first: assert property ($rose(|o_psel) |-> !o_penable)
		else $error("select rose with enable high");
	a_setup_access: assert property (s_setup |=> o_penable && $stable(o_psel))
		else $error("setup not followed by access");
	a_access_hold: assert property (o_penable && $past(o_penable) |-> $stable(o_paddr) && $stable(o_pwrite) && $stable(o_pwdata))
		else $error("address or data moved in access");
	a_sel_onehot: assert property ($onehot0(o_psel))
		else $error("more than one select");
	a_sel_region: assert property ($rose(|o_psel) |-> o_psel[o_paddr[13:10]])
		else $error("select does not match region");
	a_no_split: assert property (o_hresp[1] == 1'b0)
		else $error("split or retry response");
	a_read_stall: assert property (rd_take |=> !o_hready_resp)
		else $error("read not stalled");
	a_read_data: assert property (s_done ##0 !o_pwrite && !i_pslverr && !i_big_endian |=> o_hrdata == $past(i_prdata))
		else $error("read data not returned");
	a_err_two: assert property (o_hresp == HRESP_ERROR && !o_hready_resp |=> o_hresp == HRESP_ERROR && o_hready_resp)
		else $error("error response not two cycles");
endmodule : hab_checker
bind hab_bridge hab_checker i_hab_checker (.*);
`default_nettype wire

// >>> hab_per_model.sv
/* Peripheral model: one word per slot, wait states, slave error.
   Assumes ticks given by i_pclk_en on the core clock. */
`timescale 1ns/1ps
`default_nettype none
module hab_per_model
	import hab_pkg::*;
(
	input  wire logic [NUM_SLV-1:0] i_psel,
	input  wire logic               i_core_clk,
	input  wire logic               i_pclk_en,
	input  wire logic [1:0]         i_wait,
	input  wire logic               i_err,
	input  wire logic               i_penable,
	input  wire logic               i_pwrite,
	input  wire logic [ADDR_W-1:0]  i_paddr,
	input  wire logic [PER_DW-1:0]  i_pwdata,
	output logic      [PER_DW-1:0]  o_prdata,
	output logic                    o_pready,
	output logic                    o_pslverr
);
	logic [PER_DW-1:0] mem_r [NUM_SLV];
	logic [1:0]        cnt_r = 2'h0;
	wire  [3:0]        idx = i_paddr[13:10];
	initial o_prdata = 32'h0;
	assign o_pready  = i_penable && cnt_r == i_wait;
	assign o_pslverr = o_pready && i_err && !i_pwrite;
	// Outside a read the data flips each tick, except in a write access, so stale data never matches.
	always @(posedge i_core_clk) if (i_pclk_en) begin
		cnt_r <= (i_penable && !o_pready) ? cnt_r + 2'h1 : 2'h0;
		if (|i_psel && !i_penable && !i_pwrite)
			o_prdata <= mem_r[idx];
		else if (!i_penable)
			o_prdata <= ~o_prdata;
		if (o_pready && i_pwrite)
			mem_r[idx] <= i_pwdata;
	end
endmodule : hab_per_model
`default_nettype wire

// >>> hab_bridge_tb.sv
/* Self-checking bench for hab_bridge with the peripheral model.
   The bench is the only system bus master; bus ready is the bridge's. */
`timescale 1ns/1ps
`default_nettype none
module hab_bridge_tb;
	import hab_pkg::*;
	logic        clk = 0, rst = 1, pen = 1, slow = 0, hsel = 0;
	logic        hw = 0, be = 0, err = 0, dp = 0;
	logic [1:0]  htr = HTRANS_IDLE, wt = 2'h0, rs, div = 2'h0;
	logic [2:0]  hbu = 3'h0;
	logic [31:0] ha = 0, hwd = 0, rd;
	int          failures = 0, total_checks = 0, cyc = 0;
	wire         hr, pena, pwr, prdy, perr;
	wire [1:0]   hresp;
	wire [15:0]  psel;
	wire [31:0]  hrd, pa, pwd, prd;
	hab_bridge i_hab_bridge (.i_core_clk(clk), .i_reset(rst),
		.i_pclk_en(pen), .i_hsel(hsel), .i_haddr(ha), .i_htrans(htr),
		.i_hwrite(hw), .i_hsize(3'h2), .i_hburst(hbu), .i_hready(hr),
		.i_hwdata(hwd), .i_big_endian(be), .o_hready_resp(hr),
		.o_hresp(hresp), .o_hrdata(hrd), .o_psel(psel), .o_penable(pena),
		.o_pwrite(pwr), .o_paddr(pa), .o_pwdata(pwd), .i_prdata(prd),
		.i_pready(prdy), .i_pslverr(perr));
	hab_per_model i_hab_per_model (.i_core_clk(clk), .i_pclk_en(pen),
		.i_wait(wt), .i_err(err), .i_psel(psel), .i_penable(pena),
		.i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd),
		.o_pready(prdy), .o_pslverr(perr));
	initial forever #2.5 clk = ~clk;
	// The tick comes from a register, one core cycle in three when slow.
	always @(posedge clk) begin
		div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
		pen <= !slow || div == 2'h1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			end_of_test();
		end
	end
	task automatic check(input string n, input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic wait_rdy;
		for (int k = 0; k < 60 && !hr; k++) @(posedge clk) #1;
	endtask
	task automatic xfer(input logic w, input logic [31:0] a, d,
		input logic [1:0] t);
		hsel = 1;
		ha = a;
		hw = w;
		htr = t;
		wait_rdy();
		@(posedge clk) #1;
		hsel = 0;
		htr = HTRANS_IDLE;
		hwd = d;
		dp = hr;
		wait_rdy();
		rd = hrd;
		rs = hresp;
		@(posedge clk) #1;
	endtask
	task automatic sc_map;
		for (int s = 0; s < NUM_SLV; s++) begin
			hbu = s[2:0];
			xfer(1, (s << 10) + 32'h3fc, 32'hc0de_0000 + s, {1'b1, s[0]});
			check("posted", dp, 1'b1);
			xfer(0, s << 10, 0, HTRANS_NONSEQ);
			check("rd_stall", dp, 1'b0);
			check("rdata", rd, 32'hc0de_0000 + s);
			check("okay", rs, HRESP_OKAY);
		end
	endtask
	task automatic sc_b2b;
		hsel = 1;
		hw = 1;
		ha = 32'h400;
		htr = HTRANS_NONSEQ;
		wait_rdy();
		@(posedge clk) #1;
		hwd = 32'ha5a5_0001;
		ha = 32'h800;
		wait_rdy();
		@(posedge clk) #1;
		hsel = 0;
		htr = HTRANS_IDLE;
		hwd = 32'ha5a5_0002;
		check("queued", hr, 1'b0);
		wait_rdy();
		@(posedge clk) #1;
		xfer(0, 32'h400, 0, HTRANS_NONSEQ);
		check("b2b0", rd, 32'ha5a5_0001);
		xfer(0, 32'h800, 0, HTRANS_NONSEQ);
		check("b2b1", rd, 32'ha5a5_0002);
	endtask
	task automatic sc_idle;
		hsel = 1;
		for (int k = 0; k < 4; k++) begin
			htr = k[0] ? HTRANS_BUSY : HTRANS_IDLE;
			@(posedge clk) #1;
			check("idle", {psel, hr}, 17'h1);
		end
		hsel = 0;
		htr = HTRANS_IDLE;
	endtask
	task automatic sc_err_slow;
		wt = 2'h2;
		err = 1;
		xfer(0, 32'h1400, 0, HTRANS_NONSEQ);
		check("err", rs, HRESP_ERROR);
		err = 0;
		xfer(0, 32'h1400, 0, HTRANS_NONSEQ);
		check("wait_rd", rd, 32'hc0de_0005);
		slow = 1;
		xfer(1, 32'hc00, 32'h5a5a_0003, HTRANS_NONSEQ);
		xfer(0, 32'hc00, 0, HTRANS_NONSEQ);
		check("slow_rd", rd, 32'h5a5a_0003);
		slow = 0;
		wt = 2'h0;
	endtask
	task automatic sc_endian;
		be = 1;
		xfer(1, 32'h1800, 32'h1122_3344, HTRANS_NONSEQ);
		xfer(0, 32'h1800, 0, HTRANS_NONSEQ);
		check("be_rd", rd, 32'h1122_3344);
		be = 0;
		xfer(0, 32'h1800, 0, HTRANS_NONSEQ);
		check("le_rd", rd, 32'h4433_2211);
	endtask
	task automatic end_of_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		#1 rst = 0;
		sc_map();
		sc_b2b();
		sc_idle();
		sc_err_slow();
		sc_endian();
		end_of_test();
	end
endmodule : hab_bridge_tb
`default_nettype wire
